// ==== mal_pkg.sv ====
// Shared constants and types for the memory access lock block.
// Assumes one 20 MHz clock, ref_clk, and active-low resets.
`default_nettype none

package mal_pkg;

  typedef enum logic [2:0] {
    SEC_SRAM, SEC_IO, SEC_FLASH, SEC_EEPROM,
    SEC_USER, SEC_SIG, SEC_FUSE, SEC_SIB
  } mal_sec_t;

  typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_ERASE} mal_cmd_t;

  typedef enum logic [2:0] {
    OP_IO_IN, OP_IO_OUT, OP_LOAD, OP_STORE,
    OP_BIT_SET, OP_BIT_CLR, OP_BIT_TEST
  } mal_op_t;

  localparam int ADDR_W = 12;
  localparam int MEM_AW = 4;
  localparam int NUM_SEC = 8;
  localparam int SEC_W = 3;
  localparam int CMD_W = 2;

  localparam logic [ADDR_W-1:0] IO_DIRECT_LAST = 12'h03F;
  localparam logic [ADDR_W-1:0] IO_EXT_LAST = 12'hFFF;
  localparam logic [ADDR_W-1:0] IO_BIT_LAST = 12'h01F;
  localparam logic [ADDR_W-1:0] SCRATCH_FIRST = 12'h01C;
  localparam logic [ADDR_W-1:0] SCRATCH_LAST = 12'h01F;
  localparam int SCRATCH_NUM = 4;
  localparam int SCR_IDX_W = 2;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;

  localparam int SIG_LEN = 3;
  localparam int SIG_IDX_W = 2;
  localparam int SIB_LEN = 4;
  localparam int SIB_IDX_W = 2;

  localparam logic [MEM_AW-1:0] LOCK_IDX = 4'hA;
  localparam logic [7:0] LOCK_VALID = 8'hC5;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] CORRUPT_BYTE = 8'h00;

  localparam logic [3:0] HREG_ADDR_LO = 4'h0;
  localparam logic [3:0] HREG_ADDR_HI = 4'h1;
  localparam logic [3:0] HREG_SEC = 4'h2;
  localparam logic [3:0] HREG_DATA = 4'h3;
  localparam logic [3:0] HREG_GO = 4'h4;
  localparam logic [3:0] HREG_STATUS = 4'h5;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;

endpackage

`default_nettype wire

// ==== mal_if.sv ====
// Debug link between the external programmer and the protected device.
// Assumes both ends run on the same ref_clk supplied by the bench.
`default_nettype none

interface mal_if;
  import mal_pkg::*;

  // Request side, driven by the programmer.
  logic                req;
  mal_cmd_t            cmd;
  mal_sec_t            sec;
  logic [ADDR_W-1:0]   addr;
  logic [7:0]          wdata;
  // Answer side, driven by the device.
  logic                ack;
  logic [7:0]          rdata;

  modport device (
    input  req,
    input  cmd,
    input  sec,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );

  modport host (
    output req,
    output cmd,
    output sec,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface

`default_nettype wire

// ==== mal_scratch_reg.sv ====
// One eight-bit scratch I/O register with byte write and single-bit ops.
// Assumes write and bit strobes come from logic on ref_clk.
`default_nettype none

module mal_scratch_reg #(
  parameter logic [7:0] RESET_VAL = mal_pkg::SCRATCH_RESET
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  input  wire logic       setEn,
  input  wire logic       clrEn,
  input  wire logic [2:0] bitSel,
  output logic      [7:0] q
);
  import mal_pkg::*;

  // A byte write wins; bit ops leave every other bit untouched.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= RESET_VAL;
    end else if (wrEn) begin
      q <= wrData;
    end else if (setEn) begin
      q[bitSel] <= 1'h1;
    end else if (clrEn) begin
      q[bitSel] <= 1'h0;
    end
  end
endmodule

`default_nettype wire

// ==== mal_device.sv ====
// Device end: memory sections, lock state and access gating.
// Assumes the CPU port and the debug link are driven on ref_clk.
`default_nettype none

module mal_device #(
  parameter int AW = mal_pkg::MEM_AW,
  // Identification bytes; values are arbitrary.
  parameter logic [7:0] SIG_ID [mal_pkg::SIG_LEN] = '{8'h5A, 8'h3C, 8'h01},
  parameter logic [7:0] SIB_INFO [mal_pkg::SIB_LEN] =
    '{8'h10, 8'h20, 8'h30, 8'h40}
) (
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  input  wire logic                      porn,
  input  wire logic                      cpuReq,
  input  wire mal_pkg::mal_op_t          cpuOp,
  input  wire mal_pkg::mal_sec_t         cpuSec,
  input  wire logic [mal_pkg::ADDR_W-1:0] cpuAddr,
  input  wire logic [2:0]                cpuBit,
  input  wire logic [7:0]                cpuWdata,
  output logic                           cpuAck,
  output logic                           cpuDenied,
  output logic [7:0]                     cpuRdata,
  output logic                           cpuBitState,
  output logic                           lockedState,
  mal_if.device                          dbg
);
  import mal_pkg::*;

  localparam int DEPTH = 1 << AW;

  logic [7:0] mem [NUM_SEC][DEPTH];
  logic [7:0] scrQ [SCRATCH_NUM];
  logic       lockedFf;
  logic       loadPendFf;
  logic       cpuOk;
  logic       cpuWr;
  logic       cpuGo;
  logic       dbgOk;
  logic       dbgWrGo;
  logic       dbgEraseGo;
  logic       cpuAckFf;
  logic       cpuDeniedFf;
  logic [7:0] cpuRdataFf;
  logic       cpuBitFf;
  logic [7:0] cpuByte;
  logic       dbgAckFf;
  logic [7:0] dbgRdataFf;

  // Address falls on one of the scratch registers.
  function automatic logic scrHit(logic [ADDR_W-1:0] a);
    return (a >= SCRATCH_FIRST) && (a <= SCRATCH_LAST);
  endfunction

  // Byte a section holds at an address; unmapped I/O reads zero.
  function automatic logic [7:0] readByte(mal_sec_t s,
                                          logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = '0;
    unique case (s)
      SEC_IO: begin
        if (scrHit(a)) begin
          v = scrQ[a[SCR_IDX_W-1:0]];
        end
      end
      SEC_SIG: begin
        if (a < SIG_LEN) begin
          v = SIG_ID[a[SIG_IDX_W-1:0]];
        end
      end
      SEC_SIB: v = SIB_INFO[a[SIB_IDX_W-1:0]];
      SEC_SRAM, SEC_FLASH, SEC_EEPROM, SEC_USER, SEC_FUSE: begin
        v = mem[s][a[AW-1:0]];
      end
    endcase
    return v;
  endfunction

  // Factory content: all erased, lock field holding the valid value.
  function automatic logic [7:0] factoryByte(int s, int i);
    if (s == int'(SEC_FUSE) && i == int'(LOCK_IDX)) begin
      return LOCK_VALID;
    end
    return ERASED_BYTE;
  endfunction

  // CPU rights depend only on op, section and address, never on lock.
  always_comb begin
    cpuOk = 1'h0;
    cpuWr = 1'h0;
    unique case (cpuOp)
      OP_IO_IN: begin
        cpuOk = (cpuSec == SEC_IO) && (cpuAddr <= IO_DIRECT_LAST);
      end
      OP_IO_OUT: begin
        cpuWr = 1'h1;
        cpuOk = (cpuSec == SEC_IO) && (cpuAddr <= IO_DIRECT_LAST);
      end
      OP_LOAD: begin
        cpuOk = (cpuSec == SEC_IO) ? (cpuAddr <= IO_EXT_LAST)
                                   : (cpuSec != SEC_SIB);
      end
      OP_STORE: begin
        cpuWr = 1'h1;
        cpuOk = (cpuSec == SEC_IO) ? (cpuAddr <= IO_EXT_LAST)
              : (cpuSec inside {SEC_SRAM, SEC_FLASH, SEC_USER});
      end
      OP_BIT_SET, OP_BIT_CLR: begin
        cpuWr = 1'h1;
        cpuOk = (cpuSec == SEC_IO) && (cpuAddr <= IO_BIT_LAST);
      end
      OP_BIT_TEST: begin
        cpuOk = (cpuSec == SEC_IO) && (cpuAddr <= IO_BIT_LAST);
      end
      default: cpuOk = 1'h0;
    endcase
  end

  assign cpuGo = cpuReq && cpuOk;

  // Byte the CPU request points at, shared by reads and bit tests.
  always_comb begin
    cpuByte = readByte(cpuSec, cpuAddr);
  end

  // Debug read and write rights follow the latched lock state; erase is always allowed.
  always_comb begin
    dbgOk = 1'h0;
    unique case (dbg.cmd)
      CMD_READ: begin
        dbgOk = lockedFf ? (dbg.sec inside {SEC_SIG, SEC_SIB})
                         : 1'h1;
      end
      CMD_WRITE: begin
        dbgOk = lockedFf ? (dbg.sec == SEC_USER)
                         : !(dbg.sec inside {SEC_SIG, SEC_SIB});
      end
      CMD_ERASE: dbgOk = 1'h1;
      default: dbgOk = 1'h0;
    endcase
  end

  assign dbgWrGo = dbg.req && dbgOk && (dbg.cmd == CMD_WRITE);
  assign dbgEraseGo = dbg.req && (dbg.cmd == CMD_ERASE);

  // Nonvolatile and SRAM bytes; a debug write lands after a CPU write.
  always_ff @(posedge ref_clk or negedge porn) begin
    if (!porn) begin
      for (int s = 0; s < NUM_SEC; s++) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem[s][i] <= factoryByte(s, i);
        end
      end
    end else if (dbgEraseGo) begin
      for (int s = 0; s < NUM_SEC; s++) begin
        for (int i = 0; i < DEPTH; i++) begin
          if (s != int'(SEC_USER)) begin
            mem[s][i] <= factoryByte(s, i);
          end
        end
      end
    end else begin
      if (cpuGo && cpuWr && cpuSec != SEC_IO) begin
        mem[cpuSec][cpuAddr[AW-1:0]] <= cpuWdata;
      end
      if (dbgWrGo && dbg.sec != SEC_IO) begin
        mem[dbg.sec][dbg.addr[AW-1:0]] <= dbg.wdata;
      end
    end
  end

  // Lock is caught from the fuse one edge after reset release.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lockedFf <= 1'h1;
      loadPendFf <= 1'h1;
    end else if (dbgEraseGo) begin
      lockedFf <= 1'h0;
      loadPendFf <= 1'h0;
    end else if (loadPendFf) begin
      lockedFf <= (mem[SEC_FUSE][LOCK_IDX] != LOCK_VALID);
      loadPendFf <= 1'h0;
    end
  end

  // Scratch registers; the debug port wins a same-cycle byte write.
  for (genvar g = 0; g < SCRATCH_NUM; g++) begin : gScratch
    logic dbgHit;
    logic cpuHit;
    assign dbgHit = dbgWrGo && (dbg.sec == SEC_IO) && scrHit(dbg.addr)
                    && (dbg.addr[SCR_IDX_W-1:0] == SCR_IDX_W'(g));
    assign cpuHit = cpuGo && scrHit(cpuAddr)
                    && (cpuAddr[SCR_IDX_W-1:0] == SCR_IDX_W'(g));
    mal_scratch_reg #(
      .RESET_VAL (SCRATCH_RESET)
    ) uScratch (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .wrEn    (dbgHit || (cpuHit && cpuOp inside {OP_IO_OUT, OP_STORE})),
      .wrData  (dbgHit ? dbg.wdata : cpuWdata),
      .setEn   (cpuHit && cpuOp == OP_BIT_SET),
      .clrEn   (cpuHit && cpuOp == OP_BIT_CLR),
      .bitSel  (cpuBit),
      .q       (scrQ[g])
    );
  end

  // CPU answer, one edge after every request.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpuAckFf <= 1'h0;
      cpuDeniedFf <= 1'h0;
      cpuRdataFf <= '0;
      cpuBitFf <= 1'h0;
    end else begin
      cpuAckFf <= cpuReq;
      cpuDeniedFf <= cpuReq && !cpuOk;
      cpuRdataFf <= (cpuGo && !cpuWr) ? cpuByte : '0;
      cpuBitFf <= cpuGo && (cpuOp == OP_BIT_TEST)
                  && cpuByte[cpuBit];
    end
  end

  // Debug answer: denied reads complete normally with corrupt data.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dbgAckFf <= 1'h0;
      dbgRdataFf <= '0;
    end else begin
      dbgAckFf <= dbg.req;
      if (dbg.req && dbg.cmd == CMD_READ) begin
        dbgRdataFf <= dbgOk ? readByte(dbg.sec, dbg.addr)
                            : CORRUPT_BYTE;
      end else begin
        dbgRdataFf <= '0;
      end
    end
  end

  assign cpuAck = cpuAckFf;
  assign cpuDenied = cpuDeniedFf;
  assign cpuRdata = cpuRdataFf;
  assign cpuBitState = cpuBitFf;
  assign lockedState = lockedFf;
  assign dbg.ack = dbgAckFf;
  assign dbg.rdata = dbgRdataFf;
endmodule

`default_nettype wire

// ==== mal_debug_host.sv ====
// Programmer end: turns register orders into debug link transfers.
// Assumes the device answers each request with ack on a later edge.
`default_nettype none

module mal_debug_host (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  mal_if.host             dbg
);
  import mal_pkg::*;

  typedef enum logic {H_IDLE, H_WAIT} mal_hstate_t;

  mal_hstate_t       stateFf;
  logic [ADDR_W-1:0] addrFf;
  mal_sec_t          secFf;
  mal_cmd_t          cmdFf;
  logic [7:0]        dataFf;
  logic              reqFf;
  logic              doneFf;
  logic [7:0]        regRdataFf;
  logic              goWr;
  logic              idleWr;

  assign idleWr = regWr && (stateFf == H_IDLE);
  assign goWr = idleWr && (regAddr == HREG_GO);

  // Order registers; they hold still while a transfer is in flight.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      addrFf <= '0;
      secFf <= SEC_SRAM;
      cmdFf <= CMD_READ;
    end else if (idleWr) begin
      if (regAddr == HREG_ADDR_LO) begin
        addrFf[7:0] <= regWdata;
      end
      if (regAddr == HREG_ADDR_HI) begin
        addrFf[ADDR_W-1:8] <= regWdata[ADDR_W-9:0];
      end
      if (regAddr == HREG_SEC) begin
        secFf <= mal_sec_t'(regWdata[SEC_W-1:0]);
      end
      if (regAddr == HREG_GO) begin
        cmdFf <= mal_cmd_t'(regWdata[CMD_W-1:0]);
      end
    end
  end

  // Data register: write data out, read data back on ack.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dataFf <= '0;
    end else if (stateFf == H_WAIT && dbg.ack && cmdFf == CMD_READ) begin
      dataFf <= dbg.rdata;
    end else if (idleWr && regAddr == HREG_DATA) begin
      dataFf <= regWdata;
    end
  end

  // Sequencer: one-cycle request, then wait for the answer.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stateFf <= H_IDLE;
      reqFf <= 1'h0;
      doneFf <= 1'h0;
    end else begin
      reqFf <= goWr;
      unique case (stateFf)
        H_IDLE: begin
          if (goWr) begin
            stateFf <= H_WAIT;
            doneFf <= 1'h0;
          end
        end
        H_WAIT: begin
          if (dbg.ack) begin
            stateFf <= H_IDLE;
            doneFf <= 1'h1;
          end
        end
      endcase
    end
  end

  // Register read data, valid in the cycle after the read strobe.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdataFf <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        HREG_ADDR_LO: regRdataFf <= addrFf[7:0];
        HREG_ADDR_HI: regRdataFf <= {4'h0, addrFf[ADDR_W-1:8]};
        HREG_SEC:     regRdataFf <= {5'h00, secFf};
        HREG_DATA:    regRdataFf <= dataFf;
        HREG_GO:      regRdataFf <= {6'h00, cmdFf};
        HREG_STATUS: begin
          regRdataFf <= '0;
          regRdataFf[ST_BUSY] <= (stateFf == H_WAIT);
          regRdataFf[ST_DONE] <= doneFf;
        end
        default:      regRdataFf <= '0;
      endcase
    end else begin
      regRdataFf <= '0;
    end
  end

  assign regRdata = regRdataFf;
  assign dbg.req = reqFf;
  assign dbg.cmd = cmdFf;
  assign dbg.sec = secFf;
  assign dbg.addr = addrFf;
  assign dbg.wdata = dataFf;
endmodule

`default_nettype wire

// ==== mal_checker.sv ====
// Checker for the debug link shared by the programmer and device ends.
// Assumes the bench wires it to the interface that joins the two ends.
`default_nettype none

module mal_checker #(
  parameter logic [7:0] SIG_FIRST = 8'h5A, // Arbitrary value.
  parameter logic [7:0] SIB_FIRST = 8'h10  // Arbitrary value.
) (
  input wire logic                        ref_clk,
  input wire logic                        resetn,
  input wire logic                        req,
  input wire mal_pkg::mal_cmd_t           cmd,
  input wire mal_pkg::mal_sec_t           sec,
  input wire logic [mal_pkg::ADDR_W-1:0]  addr,
  input wire logic                        ack,
  input wire logic [7:0]                  rdata,
  input wire logic                        lockedState
);
  import mal_pkg::*;

  // All checks run on the system clock and rest during reset.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Each request gets exactly one answer, one cycle later.
  ack_follows_req_a: assert property (req |=> ack)
    else $error("link answer missing after request");
  ack_has_cause_a: assert property (ack |-> $past(req))
    else $error("link answer without a request");
  req_held_a: assert property (req |=> $stable(addr) && $stable(sec))
    else $error("request fields moved while busy");

  // Signature bytes sit at the bottom of their own space.
  sig_first_a: assert property (req && cmd == CMD_READ &&
    sec == SEC_SIG && addr == 12'h000 |=> rdata == SIG_FIRST)
    else $error("wrong first signature byte");
  sig_beyond_a: assert property (req && cmd == CMD_READ &&
    sec == SEC_SIG && addr > 12'h002 |=> rdata == 8'h00)
    else $error("data beyond the signature bytes");
  sib_read_a: assert property (req && cmd == CMD_READ &&
    sec == SEC_SIB && addr[1:0] == 2'h0 |=> rdata == SIB_FIRST)
    else $error("system info block read failed");

  // A locked part hands back filler for protected sections.
  locked_read_a: assert property (lockedState && req &&
    cmd == CMD_READ && sec != SEC_SIG && sec != SEC_SIB
    |=> ack && rdata == CORRUPT_BYTE)
    else $error("protected data leaked while locked");
  erase_unlock_a: assert property (req && cmd == CMD_ERASE
    |=> !lockedState)
    else $error("full erase did not unlock");

  // Main scenarios reached by the bench.
  cover property (req && cmd == CMD_ERASE);
  cover property (lockedState && req && cmd == CMD_READ);
  cover property (lockedState && req && cmd == CMD_WRITE && sec == SEC_USER);
endmodule

`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench: device and programmer ends joined by one link.
// Assumes the register port protocol and timing of the programmer end.
`default_nettype none

`define MAL_CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH at %0t: got %h want %h", $time, (a), (e)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mal_pkg::*;

  // Identification bytes; values are arbitrary and match the device's.
  localparam logic [7:0] SIG_EXP [SIG_LEN] = '{8'h5A, 8'h3C, 8'h01};
  localparam logic [7:0] SIB_EXP           = 8'h10;

  logic              ref_clk   = 1'b0;
  logic              resetn    = 1'b0;
  logic              porn      = 1'b0;
  logic              cpuReq    = 1'b0;
  mal_op_t           cpuOp     = OP_IO_IN;
  mal_sec_t          cpuSec    = SEC_SRAM;
  logic [ADDR_W-1:0] cpuAddr   = 12'h000;
  logic [2:0]        cpuBit    = 3'h0;
  logic [7:0]        cpuWdata  = 8'h00;
  logic [3:0]        regAddr   = 4'h0;
  logic [7:0]        regWdata  = 8'h00;
  logic              regWr     = 1'b0;
  logic              regRd     = 1'b0;
  logic              cpuAck, cpuDenied, cpuBitState, lockedState;
  logic [7:0]        cpuRdata, regRdata, got, rnd, flashLast, userVal;
  int                fails     = 0;
  int                checked   = 0;
  mal_sec_t          denySec [3] = '{SEC_EEPROM, SEC_SIG, SEC_FUSE};

  // Free-running 20 MHz system clock.
  always #25 ref_clk = ~ref_clk;

  mal_if u_mal_if ();

  mal_device u_mal_device (
    .ref_clk(ref_clk), .resetn(resetn), .porn(porn), .cpuReq(cpuReq),
    .cpuOp(cpuOp), .cpuSec(cpuSec), .cpuAddr(cpuAddr), .cpuBit(cpuBit),
    .cpuWdata(cpuWdata), .cpuAck(cpuAck), .cpuDenied(cpuDenied),
    .cpuRdata(cpuRdata), .cpuBitState(cpuBitState),
    .lockedState(lockedState), .dbg(u_mal_if.device)
  );

  mal_debug_host u_mal_debug_host (
    .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .dbg(u_mal_if.host)
  );

  mal_checker u_mal_checker (
    .ref_clk(ref_clk), .resetn(resetn), .req(u_mal_if.req),
    .cmd(u_mal_if.cmd), .sec(u_mal_if.sec), .addr(u_mal_if.addr),
    .ack(u_mal_if.ack), .rdata(u_mal_if.rdata), .lockedState(lockedState)
  );

  // Next value of the stimulus shift register.
  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Expected signature byte; the space reads zero past its end.
  function automatic logic [7:0] sigByte(input int i);
    return (i < SIG_LEN) ? SIG_EXP[i] : 8'h00;
  endfunction

  // One CPU request; the answer is sampled in the cycle it stands.
  task automatic cpuRun(input mal_op_t op, input mal_sec_t s,
                        input logic [11:0] a, input logic [2:0] b,
                        input logic [7:0] d);
    @(posedge ref_clk);
    cpuReq <= 1'b1;
    cpuOp <= op;
    cpuSec <= s;
    cpuAddr <= a;
    cpuBit <= b;
    cpuWdata <= d;
    @(posedge ref_clk);
    cpuReq <= 1'b0;
    #1;
    got = cpuRdata;
    `MAL_CHK(cpuAck, 1'b1)
  endtask

  // One register write or read on the programmer's plain port.
  task automatic regAcc(input logic wr, input logic [3:0] a,
                        input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= wr;
    regRd <= !wr;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1;
  endtask

  // Full debug transfer: load the order, start it, poll done, fetch data.
  task automatic dbgOp(input mal_cmd_t c, input mal_sec_t s,
                       input logic [11:0] a, input logic [7:0] d);
    int n;
    regAcc(1'b1, HREG_ADDR_LO, a[7:0]);
    regAcc(1'b1, HREG_ADDR_HI, {4'h0, a[11:8]});
    regAcc(1'b1, HREG_SEC, {5'h00, s});
    regAcc(1'b1, HREG_DATA, d);
    regAcc(1'b1, HREG_GO, {6'h00, c});
    n = 0;
    do begin
      regAcc(1'b0, HREG_STATUS, 8'h00);
      n++;
    end while (regRdata[ST_DONE] !== 1'b1 && n < 20);
    `MAL_CHK(regRdata[ST_DONE], 1'b1)
    regAcc(1'b0, HREG_DATA, 8'h00);
    got = regRdata;
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Some 28 debug transfers of about sixteen cycles each fit easily.
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    complete_run();
  end

  // Main sequence: unlocked access, lock, locked access, erase.
  initial begin
    rnd = 8'h15;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    porn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    `MAL_CHK(lockedState, 1'b0)
    for (int i = 0; i < SCRATCH_NUM; i++) begin
      cpuRun(OP_IO_IN, SEC_IO, SCRATCH_FIRST + 12'(i), 3'h0, 8'h00);
      `MAL_CHK(got, SCRATCH_RESET)
    end
    for (int i = 0; i < 4; i++) begin
      rnd = lfsrNext(rnd);
      cpuRun(OP_STORE, SEC_SRAM, 12'(i), 3'h0, rnd);
      dbgOp(CMD_READ, SEC_SRAM, 12'(i), 8'h00);
      `MAL_CHK(got, rnd)
      rnd = lfsrNext(rnd);
      flashLast = rnd;
      dbgOp(CMD_WRITE, SEC_FLASH, 12'(i), rnd);
      cpuRun(OP_LOAD, SEC_FLASH, 12'(i), 3'h0, 8'h00);
      `MAL_CHK(got, rnd)
    end
    for (int i = 0; i < 3; i++) begin
      cpuRun(OP_STORE, denySec[i], {8'h00, LOCK_IDX}, 3'h0, 8'h00);
      `MAL_CHK(cpuDenied, 1'b1)
    end
    cpuRun(OP_LOAD, SEC_FUSE, {8'h00, LOCK_IDX}, 3'h0, 8'h00);
    `MAL_CHK(got, LOCK_VALID)
    dbgOp(CMD_WRITE, SEC_SIG, 12'h000, 8'h00);
    for (int i = 0; i < 4; i++) begin
      dbgOp(CMD_READ, SEC_SIG, 12'(i), 8'h00);
      `MAL_CHK(got, sigByte(i))
    end
    cpuRun(OP_IO_OUT, SEC_IO, 12'h01D, 3'h0, 8'hA5);
    cpuRun(OP_BIT_SET, SEC_IO, 12'h01D, 3'h1, 8'h00);
    cpuRun(OP_BIT_CLR, SEC_IO, 12'h01D, 3'h0, 8'h00);
    cpuRun(OP_IO_IN, SEC_IO, 12'h01D, 3'h0, 8'h00);
    `MAL_CHK(got, 8'hA6)
    cpuRun(OP_BIT_TEST, SEC_IO, 12'h01D, 3'h7, 8'h00);
    `MAL_CHK(cpuBitState, 1'b1)
    cpuRun(OP_BIT_TEST, SEC_IO, 12'h01D, 3'h0, 8'h00);
    `MAL_CHK(cpuBitState, 1'b0)
    cpuRun(OP_BIT_SET, SEC_IO, 12'h020, 3'h0, 8'h00);
    `MAL_CHK(cpuDenied, 1'b1)
    cpuRun(OP_IO_IN, SEC_IO, 12'h040, 3'h0, 8'h00);
    `MAL_CHK(cpuDenied, 1'b1)
    cpuRun(OP_LOAD, SEC_IO, 12'hFFF, 3'h0, 8'h00);
    `MAL_CHK(cpuDenied, 1'b0)
    rnd = lfsrNext(rnd);
    dbgOp(CMD_WRITE, SEC_EEPROM, 12'h003, rnd);
    dbgOp(CMD_READ, SEC_EEPROM, 12'h003, 8'h00);
    `MAL_CHK(got, rnd)
    rnd = lfsrNext(rnd);
    cpuRun(OP_STORE, SEC_USER, 12'h002, 3'h0, rnd);
    dbgOp(CMD_READ, SEC_USER, 12'h002, 8'h00);
    `MAL_CHK(got, rnd)
    // A bad lock value only takes hold after the next reset.
    dbgOp(CMD_WRITE, SEC_FUSE, {8'h00, LOCK_IDX}, 8'h00);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    `MAL_CHK(lockedState, 1'b1)
    dbgOp(CMD_READ, SEC_SRAM, 12'h000, 8'h00);
    `MAL_CHK(got, CORRUPT_BYTE)
    dbgOp(CMD_READ, SEC_FUSE, {8'h00, LOCK_IDX}, 8'h00);
    `MAL_CHK(got, CORRUPT_BYTE)
    dbgOp(CMD_READ, SEC_USER, 12'h002, 8'h00);
    `MAL_CHK(got, CORRUPT_BYTE)
    dbgOp(CMD_READ, SEC_SIB, 12'h000, 8'h00);
    `MAL_CHK(got, SIB_EXP)
    dbgOp(CMD_READ, SEC_SIG, 12'h001, 8'h00);
    `MAL_CHK(got, sigByte(1))
    rnd = lfsrNext(rnd);
    userVal = rnd;
    dbgOp(CMD_WRITE, SEC_USER, 12'h003, userVal);
    cpuRun(OP_LOAD, SEC_USER, 12'h003, 3'h0, 8'h00);
    `MAL_CHK(got, userVal)
    dbgOp(CMD_WRITE, SEC_FLASH, 12'h003, ~flashLast);
    cpuRun(OP_LOAD, SEC_FLASH, 12'h003, 3'h0, 8'h00);
    `MAL_CHK(got, flashLast)
    cpuRun(OP_STORE, SEC_SRAM, 12'h005, 3'h0, 8'h3C);
    cpuRun(OP_LOAD, SEC_SRAM, 12'h005, 3'h0, 8'h00);
    `MAL_CHK(got, 8'h3C)
    dbgOp(CMD_ERASE, SEC_SRAM, 12'h000, 8'h00);
    `MAL_CHK(lockedState, 1'b0)
    dbgOp(CMD_READ, SEC_FLASH, 12'h003, 8'h00);
    `MAL_CHK(got, ERASED_BYTE)
    dbgOp(CMD_READ, SEC_FUSE, {8'h00, LOCK_IDX}, 8'h00);
    `MAL_CHK(got, LOCK_VALID)
    dbgOp(CMD_READ, SEC_USER, 12'h003, 8'h00);
    `MAL_CHK(got, userVal)
    cpuRun(OP_IO_IN, SEC_IO, 12'h01D, 3'h0, 8'h00);
    `MAL_CHK(got, SCRATCH_RESET)
    complete_run();
  end
endmodule

`default_nettype wire
